// ### hdl/qdsl_regs.svh
// Register offsets, field positions, reset values and timing counts of the loader
`ifndef QDSL_REGS_SVH
`define QDSL_REGS_SVH
`define QDSL_CTRL_OFS 12'h000
`define QDSL_STAT_OFS 12'h004
`define QDSL_CTRL_EN_BIT 0
`define QDSL_CTRL_RST 32'h0000_0001
`define QDSL_STAT_MODE_BIT 0
`define QDSL_STAT_CNT_LSB 4
`define QDSL_STAT_CMD_LSB 12
`define QDSL_WORD_BITS 16
`define QDSL_CODE_BITS 12
`define QDSL_NUM_CH 4
`define QDSL_SYNC_STAGES 2
`endif

// ### hdl/qdsl_pkg.sv
// Types shared by the loader files
package qdsl_pkg;
   // Echo edge modes, one-hot
   typedef enum logic [1:0] {
      QDSL_MODE0 = 2'h1,
      QDSL_MODE1 = 2'h2
   } qdsl_mode_e;
   typedef logic [11:0] qdsl_code_t;
   typedef logic [15:0] qdsl_word_t;
endpackage

// ### hdl/qdsl_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module qdsl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = {W{1'b0}}
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage is read by the second stage only
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_ff <= RST;
         q_ff <= RST;
      end
      else
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// ### hdl/qdsl_loader.sv
// Quad DAC serial loader: link front end, command decode, double buffers, APB slave
//
// Notes on behaviour
// - One 16-bit word per frame, MSB first, acted on at select rise whatever the bit count.
// - Word is two address bits, two control bits, then twelve code bits.
// - Address/control nibble picks registers, latch behaviour and echo edge.
// - Select high: shift clock and data ignored, echo released high.
// - Select low: serial input shifts in on each rising shift-clock edge.
// - Select rising edge executes the decoded command.
// - Four channels, each a 12-bit input register feeding a DAC register.
// - Load-DAC high: load inputs only, load DACs, or update all DACs.
// - Load-DAC low: DAC registers transparent, updates land at select rise.
// - Load-DAC low copies all input registers into DAC registers.
// - Load-all writes one code into every input and DAC register.
// - No-op leaves every input and DAC register unchanged.
// - Echo-edge command also copies all inputs into DAC registers.
// - Echo shows shift register output; stored codes are never shifted out.
// - Echo changes on rising edges in mode 1, falling edges in mode 0.
// - Echo lags input by 16.5 cycles in mode 0, 16 in mode 1.
// - Start in mode 1 after reset.
// - DAC code is straight binary 0 to 4095.
// - Control 01, load-DAC high: load addressed input register only.
// - Control 11, load-DAC high: load addressed input, then update all DACs.
// - Control 00 load-all or no-op; control 10 updates all, and sets mode when the high address bit is set.
// - Load-DAC low, control low bit set: load input and its DAC at once.
`timescale 1ns/1ps
`include "qdsl_regs.svh"
module qdsl_loader (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic select_n,
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic load_dac_n,
   output logic echo_out,
   output logic echo_oe,
   output qdsl_pkg::qdsl_code_t dac_code_a,
   output qdsl_pkg::qdsl_code_t dac_code_b,
   output qdsl_pkg::qdsl_code_t dac_code_c,
   output qdsl_pkg::qdsl_code_t dac_code_d
);
   localparam int NCH = `QDSL_NUM_CH;
   localparam logic [31:0] CTRL_RST = `QDSL_CTRL_RST;

   logic [3:0] pin_s;
   logic sel_n_s;
   logic sck_s;
   logic sin_s;
   logic load_dac_n_n_s;
   logic sel_n_q_ff;
   logic sck_q_ff;
   qdsl_pkg::qdsl_word_t sr_ff;
   logic out_bit_ff;
   logic echo_ff;
   logic echo_oe_ff;
   qdsl_pkg::qdsl_mode_e mode_ff;
   qdsl_pkg::qdsl_mode_e nxt_mode;
   qdsl_pkg::qdsl_code_t inp_ff [NCH];
   qdsl_pkg::qdsl_code_t dac_ff [NCH];
   logic [4:0] bit_cnt_ff;
   logic [4:0] last_cnt_ff;
   logic [3:0] last_cmd_ff;
   logic link_en_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // Pins pass two flops; reset to idle levels so no false edge follows reset
   qdsl_sync #(.W(4), .RST(4'h9)) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .d({select_n, shift_clk, serial_in, load_dac_n}),
      .q(pin_s)
   );
   assign sel_n_s = pin_s[3];
   assign sck_s = pin_s[2];
   assign sin_s = pin_s[1];
   assign load_dac_n_n_s = pin_s[0];

   // Edge detection on synchronised link signals; disabled link looks deselected
   wire selected = !sel_n_s && link_en_ff;
   wire sck_rise = sck_s && !sck_q_ff && selected;
   wire sck_fall = !sck_s && sck_q_ff && selected;
   wire sel_rise = sel_n_s && !sel_n_q_ff && link_en_ff;

   // Command fields of the last sixteen bits held
   wire addr_hi = sr_ff[15];
   wire addr_lo = sr_ff[14];
   wire ctrl_hi = sr_ff[13];
   wire ctrl_lo = sr_ff[12];
   wire [1:0] chan = sr_ff[15:14];
   wire [11:0] code = sr_ff[11:0];

   // Command decode, qualified by the select rising edge
   wire cmd_go = sel_rise;
   wire load_all = cmd_go && !ctrl_hi && !ctrl_lo && !addr_lo;
   wire load_one = cmd_go && ctrl_lo;
   wire upd_all = cmd_go && ctrl_hi && !(ctrl_lo && !load_dac_n_n_s);
   wire set_mode = cmd_go && ctrl_hi && !ctrl_lo && addr_hi;
   wire transparent = !load_dac_n_n_s;

   assign nxt_mode = addr_lo ? qdsl_pkg::QDSL_MODE1 : qdsl_pkg::QDSL_MODE0;

   // Link edge history
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sel_n_q_ff <= 1'b1;
         sck_q_ff <= 1'b0;
      end
      else
      begin
         sel_n_q_ff <= sel_n_s;
         sck_q_ff <= sck_s;
      end
   end

   // Shift register; only rising edges while selected move it
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         sr_ff <= 16'h0000;
      else if (sck_rise)
         sr_ff <= {sr_ff[14:0], sin_s};
   end

   // Bit counter of the current frame, saturating above one word
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         bit_cnt_ff <= 5'h00;
      else if (!selected)
         bit_cnt_ff <= 5'h00;
      else if (sck_rise && bit_cnt_ff != 5'h1F)
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
   end

   // Echo path: shifted-out bit kept for half a cycle more in mode 0
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         out_bit_ff <= 1'b1;
         echo_ff <= 1'b1;
         echo_oe_ff <= 1'b0;
      end
      else
      begin
         echo_oe_ff <= selected;
         if (sck_rise)
            out_bit_ff <= sr_ff[15];
         if (!selected)
            echo_ff <= 1'b1;
         else if (sck_rise && mode_ff == qdsl_pkg::QDSL_MODE1)
            echo_ff <= sr_ff[15];
         else if (sck_fall && mode_ff == qdsl_pkg::QDSL_MODE0)
            echo_ff <= out_bit_ff;
      end
   end

   // Echo edge mode, mode 1 out of reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         mode_ff <= qdsl_pkg::QDSL_MODE1;
      else if (set_mode)
         mode_ff <= nxt_mode;
   end

   // Per-channel double buffer; straight binary codes kept as loaded
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_ch
         wire sel_me = load_one && (chan == 2'(gi));
         wire [11:0] nxt_inp = (load_all || sel_me) ? code : inp_ff[gi];
         wire dac_wr = load_all || transparent || upd_all;
         always_ff @(posedge ref_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               inp_ff[gi] <= 12'h000;
               dac_ff[gi] <= 12'h000;
            end
            else
            begin
               inp_ff[gi] <= nxt_inp;
               if (dac_wr)
                  dac_ff[gi] <= nxt_inp;
            end
         end
      end
   endgenerate

   assign dac_code_a = dac_ff[0];
   assign dac_code_b = dac_ff[1];
   assign dac_code_c = dac_ff[2];
   assign dac_code_d = dac_ff[3];

   // Frame summary for software
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         last_cnt_ff <= 5'h00;
         last_cmd_ff <= 4'h0;
      end
      else if (cmd_go)
      begin
         last_cnt_ff <= bit_cnt_ff;
         last_cmd_ff <= sr_ff[15:12];
      end
   end

   // APB decode; answer comes one cycle into the access phase
   wire apb_acc = psel && penable && pready_ff;
   wire hit_ctrl = paddr == `QDSL_CTRL_OFS;
   wire hit_stat = paddr == `QDSL_STAT_OFS;
   wire hit_any = hit_ctrl || hit_stat;
   wire [31:0] stat_word = {16'h0000, last_cmd_ff, 3'h0, last_cnt_ff, 3'h0,
                            mode_ff == qdsl_pkg::QDSL_MODE1};
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, link_en_ff} : (hit_stat ? stat_word : 32'h0);

   // Ready and read data registered so every bus output is a flop
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else
      begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !hit_any;
         prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Link enable; disabling mid-frame drops the frame without executing it
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         link_en_ff <= CTRL_RST[`QDSL_CTRL_EN_BIT];
      else if (apb_acc && pwrite && hit_ctrl)
         link_en_ff <= pwdata[`QDSL_CTRL_EN_BIT];
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign echo_out = echo_ff;
   assign echo_oe = echo_oe_ff;

   // Checks on the loader behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_load_in;
      cmd_go && load_dac_n_n_s && !ctrl_hi && ctrl_lo && chan == 2'h1;
   endsequence
   sequence s_nop;
      cmd_go && !ctrl_hi && !ctrl_lo && addr_lo && load_dac_n_n_s;
   endsequence

   property p_release;
      !selected |=> !echo_oe && echo_out;
   endproperty
   a_release: assert property (p_release) else $error("echo not released");

   property p_shift;
      sck_rise |=> sr_ff == {$past(sr_ff[14:0]), $past(sin_s)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_load_in;
      s_load_in |=> inp_ff[1] == $past(code) && dac_code_b == $past(dac_ff[1]);
   endproperty
   a_load_in: assert property (p_load_in) else $error("input load wrong");

   property p_load_all;
      load_all |=> dac_code_a == $past(code) && dac_code_d == $past(code)
         && inp_ff[2] == $past(code);
   endproperty
   a_load_all: assert property (p_load_all) else $error("load all wrong");

   property p_nop;
      s_nop |=> $stable(dac_code_c) && $stable(inp_ff[3]);
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed state");

   property p_mode;
      set_mode && !addr_lo ##1 !set_mode [*3] |-> mode_ff == qdsl_pkg::QDSL_MODE0;
   endproperty
   a_mode: assert property (p_mode) else $error("mode not set");

   property p_transp;
      !load_dac_n_n_s && !cmd_go |=> dac_code_a == inp_ff[0];
   endproperty
   a_transp: assert property (p_transp) else $error("not transparent");

   property p_upd;
      cmd_go && ctrl_hi && load_dac_n_n_s |=> dac_code_d == inp_ff[3];
   endproperty
   a_upd: assert property (p_upd) else $error("update all missed");

   property p_echo1;
      sck_rise && mode_ff == qdsl_pkg::QDSL_MODE1 |=> echo_out == $past(sr_ff[15]);
   endproperty
   a_echo1: assert property (p_echo1) else $error("mode 1 echo wrong");

   sequence s_fall0;
      sck_fall && mode_ff == qdsl_pkg::QDSL_MODE0;
   endsequence
   property p_echo0;
      s_fall0 |=> echo_out == $past(out_bit_ff);
   endproperty
   a_echo0: assert property (p_echo0) else $error("mode 0 echo wrong");

   sequence s_mode1_cmd;
      set_mode && addr_lo;
   endsequence
   property p_mode1;
      s_mode1_cmd |=> mode_ff == qdsl_pkg::QDSL_MODE1;
   endproperty
   a_mode1: assert property (p_mode1) else $error("mode 1 not set");

   sequence s_load_now;
      cmd_go && !load_dac_n_n_s && ctrl_lo && chan == 2'h2;
   endsequence
   property p_load_now;
      s_load_now |=> dac_code_c == $past(code) && inp_ff[2] == $past(code);
   endproperty
   a_load_now: assert property (p_load_now) else $error("immediate load wrong");
endmodule

// ### tb/qdsl_host_model.sv
// Host serial port model driving the loader's link pins
`timescale 1ns/1ps
module qdsl_host_model (
   output logic select_n,
   output logic shift_clk,
   output logic serial_in,
   input wire logic echo_out,
   input wire logic echo_oe
);
   logic [31:0] eh;
   logic [31:0] el;
   logic oe_all;
   // Idle: select high, clock parked low between frames
   initial
   begin
      select_n = 1'h1;
      shift_clk = 1'h0;
      serial_in = 1'h0;
   end
   // Frame of n bits, MSB first, 160 ns clock
   // Echo sampled late in each phase so both echo edges are settled
   task automatic send(input logic [31:0] w, input int n);
      #1; // Off the system clock edge, so the sampling flops never race the pins
      oe_all = 1'h1;
      select_n = 1'h0; // Lowered ahead of the first rise
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in = w[i]; // Launched opposite the capture edge
         #80;
         el = {el[30:0], echo_out};
         oe_all = oe_all & echo_oe;
         shift_clk = 1'h1;
         #77;
         eh = {eh[30:0], echo_out};
         #3;
         shift_clk = 1'h0;
      end
      #80;
      el = {el[30:0], echo_out};
      select_n = 1'h1; // Held low until every bit is
      serial_in = ~serial_in; // No stale data on the released line
      #599;
   endtask
endmodule

// ### tb/quad_dac_serial_loader_tb.sv
// Self-checking bench for the quad DAC serial loader
`timescale 1ns/1ps
module quad_dac_serial_loader_tb;
   typedef struct {
      logic [15:0] w;
      logic ld;
      logic [47:0] exp;
   } qdsl_row_s;
   logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, load_dac_n, err;
   logic select_n, shift_clk, serial_in, echo_out, echo_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   qdsl_pkg::qdsl_code_t dac_a, dac_b, dac_c, dac_d;
   int failures, num_checks;
   // Word, load pin level, expected codes A..D
   qdsl_row_s rows [17] = '{
      '{16'h0123, 1'h1, 48'h123123123123},
      '{16'h1ABC, 1'h1, 48'h123123123123},
      '{16'h5456, 1'h1, 48'h123123123123},
      '{16'h9789, 1'h1, 48'h123123123123},
      '{16'hDFFF, 1'h1, 48'h123123123123},
      '{16'h2000, 1'h1, 48'hABC456789FFF},
      '{16'h3001, 1'h1, 48'h001456789FFF},
      '{16'h5222, 1'h1, 48'h001456789FFF},
      '{16'h6000, 1'h1, 48'h001222789FFF},
      '{16'h4EEE, 1'h1, 48'h001222789FFF},
      '{16'hCEEE, 1'h1, 48'h001222789FFF},
      '{16'h1AAA, 1'h1, 48'h001222789FFF},
      '{16'h4000, 1'h0, 48'hAAA222789FFF},
      '{16'hB555, 1'h0, 48'hAAA222555FFF},
      '{16'h7333, 1'h0, 48'hAAA333555FFF},
      '{16'h1777, 1'h1, 48'hAAA333555FFF},
      '{16'hA000, 1'h1, 48'h777333555FFF}};

   qdsl_loader u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_n(select_n), .shift_clk(shift_clk), .serial_in(serial_in),
      .load_dac_n(load_dac_n), .echo_out(echo_out), .echo_oe(echo_oe), .dac_code_a(dac_a),
      .dac_code_b(dac_b), .dac_code_c(dac_c), .dac_code_d(dac_d));
   qdsl_host_model u_host (.select_n(select_n), .shift_clk(shift_clk),
      .serial_in(serial_in), .echo_out(echo_out), .echo_oe(echo_oe));

   // 100 MHz system clock
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Hang guard, well beyond the twenty-odd frames of the run
   initial
   begin
      #500000;
      failures++;
      final_report();
   end

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One APB transfer; waits on pready, only the hang guard ends a stall
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
         @(posedge ref_clk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // 32-bit frame: echo of the first half, NOP decoded from the last 16
   task automatic echo_frame(input logic m1, input logic [47:0] d);
      u_host.send({16'hB38E, 16'h4000}, 32);
      check("dac", {dac_a, dac_b, dac_c, dac_d}, d);
      check("echo_lo", u_host.el[15:0], 16'hB38E);
      if (m1)
         check("echo_hi", u_host.eh[15:0], 16'hB38E);
      else
         check("echo_hi", u_host.eh[14:0], 15'h59C7);
      check("oe", {u_host.oe_all, echo_oe, echo_out}, 3'h5);
      apb(1'h0, 12'h004, 32'h0);
      check("status", rd, 32'h41F0 | {31'h0, m1});
   endtask

   initial
   begin
      failures = 0;
      num_checks = 0;
      arst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      load_dac_n = 1'h1;
      repeat (10) @(posedge ref_clk);
      check("rst", {echo_out, echo_oe, pready, dac_a, dac_b, dac_c, dac_d}, 51'h4 << 48);
      arst_n <= 1'h1;
      apb(1'h0, 12'h000, 32'h0);
      check("ctrl", rd, 32'h1);
      apb(1'h0, 12'h004, 32'h0);
      check("mode", rd[0], 1'h1);
      apb(1'h0, 12'h008, 32'h0);
      check("unmapped", {err, rd}, 33'h1_0000_0000);
      echo_frame(1'h1, 48'h0);
      // Table rows, one frame each
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         load_dac_n <= rows[i].ld;
         u_host.send({16'h0, rows[i].w}, 16);
         check("dac", {dac_a, dac_b, dac_c, dac_d}, rows[i].exp);
      end
      echo_frame(1'h0, 48'h777333555FFF);
      // Mode 1 command, then mode 0 again so the reset below must restore mode 1
      u_host.send(32'hE000, 16);
      echo_frame(1'h1, 48'h777333555FFF);
      u_host.send(32'hA000, 16);
      // Link disabled: a load-all frame must be ignored
      apb(1'h1, 12'h000, 32'h0);
      u_host.send(32'h0FFF, 16);
      check("dis", {u_host.oe_all, dac_a, dac_b, dac_c, dac_d}, 49'h777333555FFF);
      apb(1'h1, 12'h000, 32'h1);
      // Second reset in mid-run restores mode 1 and clears codes
      @(posedge ref_clk);
      arst_n <= 1'h0;
      repeat (3) @(posedge ref_clk);
      check("rst2", {echo_oe, dac_a, dac_b, dac_c, dac_d}, 49'h0);
      arst_n <= 1'h1;
      apb(1'h0, 12'h004, 32'h0);
      check("mode", rd[0], 1'h1);
      final_report();
   end
endmodule
